// >>> verilog/liu_params.svh
// Purpose: named addresses, bit positions and reset values of the alarm/control block
// Assumes: included once per compile unit by its bare name
// Notes: address width matches the five-bit serial host address field
`ifndef LIU_PARAMS_SVH
`define LIU_PARAMS_SVH

// register addresses
`define LIU_ADDR_TXCTL 5'h03
`define LIU_ADDR_IRQEN 5'h04
`define LIU_ADDR_STAT 5'h05

// transmit control register fields
`define LIU_TXCTL_RES_HI 4
`define LIU_TXCTL_RES_LO 3
`define LIU_TXCTL_INSERT 2
`define LIU_TXCTL_RSVD 1
`define LIU_TXCTL_RATIO 0
`define LIU_TXCTL_RST 8'h00
`define LIU_TXCTL_WMASK 8'h1f

// interrupt enable register fields
`define LIU_IE_GLOBAL 7
`define LIU_IE_DRV 6
`define LIU_IE_FIFO 5
`define LIU_IE_LCV 4
`define LIU_IE_LOOP 3
`define LIU_IE_AIS 2
`define LIU_IE_LOS 1
`define LIU_IE_PAT 0
`define LIU_IRQEN_RST 8'h00

// status register fields
`define LIU_ST_DRV 6
`define LIU_ST_FIFO 5
`define LIU_ST_LCV 4
`define LIU_ST_LIVE_RST 3'h0
`define LIU_PEND_RST 7'h00
`define LIU_RDATA_RST 8'h00

`endif

// >>> verilog/liu_pkg.sv
// Purpose: shared types of the alarm/control block
// Assumes: nothing beyond SystemVerilog
// Notes: resistor codes follow the two select bits directly
package liu_pkg;

   // external receive resistor selection
   typedef enum logic [1:0] {
      LIU_RES_NONE = 2'b00,
      LIU_RES_60 = 2'b01,
      LIU_RES_52P5 = 2'b10,
      LIU_RES_37P5 = 2'b11
   } liu_rx_res_t;

   // violation insertion sequencer
   typedef enum logic [0:0] {
      LIU_BPV_IDLE = 1'b0,
      LIU_BPV_PEND = 1'b1
   } liu_bpv_state_t;

endpackage : liu_pkg

// >>> verilog/liu_bpv_insert.sv
// Purpose: turns a rising edge of the violation insert bit into one violation
// Assumes: tx_clock_i is synchronous to ref_clk_i and much slower
// Notes: the insert bit is looked at only on tx clock rising edges
`include "liu_params.svh"

module liu_bpv_insert
   import liu_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // control
   input wire logic insert_bit_i,
   input wire logic tx_clock_i,
   input wire logic prbs_active_i,
   input wire logic single_rail_i,
   // result
   output logic bpv_insert_o,
   output logic bpv_busy_o
);

   liu_bpv_state_t state_q;
   liu_bpv_state_t state_d;
   logic tx_clk_q;
   logic insert_smp_q;
   logic insert_smp_d;
   logic bpv_q;
   logic bpv_d;
   wire logic tx_edge;
   wire logic insert_rise;
   wire logic insert_ok;

   // tx clock rising edge acts as the bit-slot enable
   assign tx_edge = tx_clock_i & ~tx_clk_q;
   assign insert_rise = tx_edge & insert_bit_i & ~insert_smp_q;
   // [RULE_03] pattern or single-rail
   assign insert_ok = prbs_active_i | single_rail_i;
   assign insert_smp_d = tx_edge ? insert_bit_i : insert_smp_q;

   // next state; a request waits while neither path can carry a violation
   always_comb
   begin
      state_d = state_q;
      bpv_d = 1'b0;
      unique case (state_q)
         LIU_BPV_IDLE:
         begin
            // [RULE_02] one per rise
            if (insert_rise)
            begin
               state_d = LIU_BPV_PEND;
            end
         end
         LIU_BPV_PEND:
         begin
            if (tx_edge & insert_ok)
            begin
               bpv_d = 1'b1;
               state_d = LIU_BPV_IDLE;
            end
         end
      endcase
   end

   // state registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= LIU_BPV_IDLE;
         tx_clk_q <= 1'b0;
         insert_smp_q <= 1'b0;
         bpv_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         tx_clk_q <= tx_clock_i;
         insert_smp_q <= insert_smp_d;
         bpv_q <= bpv_d;
      end
   end

   assign bpv_insert_o = bpv_q;
   assign bpv_busy_o = (state_q == LIU_BPV_PEND);

endmodule : liu_bpv_insert

// >>> verilog/liu_alarm_ctrl.sv
// Purpose: host registers for rx resistor, tx control, interrupt enables and alarm status
// Assumes: all inputs synchronous to ref_clk_i; host port is a simple strobed register port
// Notes: pending interrupt flags clear on a status read; a new event in that cycle wins
`include "liu_params.svh"

// Overview of operation
// [RULE_01] two resistor bits select none, 60, 52.5 or 37.5 ohms; reset zero
// [RULE_02] a zero-to-one change of the insert bit inserts exactly one violation
// [RULE_03] violations go into the test pattern or single-rail data
// [RULE_04] host writes zero then one to request each further violation
// [RULE_05] external termination: ratio bit one gives 1:2, zero gives 1:2.45
// [RULE_06] internal termination: ratio fixed 1:2, ratio bit ignored
// [RULE_07] global enable bit D7 passes interrupts to the pin or masks all
// [RULE_08] enable D6 unmasks driver failure interrupts
// [RULE_09] enable D5 unmasks fifo within three bits of limit interrupts
// [RULE_10] enable D4 unmasks line code violation interrupts
// [RULE_11] enable D3 unmasks loop-code detection interrupts
// [RULE_12] enable D2 unmasks alarm indication signal interrupts
// [RULE_13] enable D1 unmasks loss-of-signal interrupts
// [RULE_14] enable D0 unmasks test pattern detection interrupts
// [RULE_15] status D6 follows the live driver failure monitor
// [RULE_16] status D5 reads one while fifo pointers are within three bits
// [RULE_17] status D4 reads one while a code violation or excess zeros is seen
// [RULE_18] either-direction change of D6, D5, D4 raises an interrupt when enabled
// [RULE_19] pending interrupt holds the pin until serviced, gated by global enable
module liu_alarm_ctrl
   import liu_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // host register port
   input wire logic [4:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // live alarm conditions
   input wire logic driver_fail_i,
   input wire logic fifo_near_limit_i,
   input wire logic line_violation_i,
   // event pulses from alarm logic held elsewhere
   input wire logic loop_code_evt_i,
   input wire logic alarm_indication_evt_i,
   input wire logic loss_of_signal_evt_i,
   input wire logic test_pattern_evt_i,
   // transmit path
   input wire logic tx_clock_i,
   input wire logic prbs_active_i,
   input wire logic single_rail_i,
   input wire logic int_term_i,
   output logic bpv_insert_o,
   output logic tx_ratio_1to2_o,
   // receive termination
   output liu_rx_res_t rx_res_sel_o,
   // interrupt pin
   output logic int_n_o
);

   logic [7:0] txctl_q;
   logic [7:0] txctl_d;
   logic [7:0] irqen_q;
   logic [7:0] irqen_d;
   logic [2:0] live_q;
   logic [6:0] pend_q;
   logic [6:0] pend_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic int_n_q;
   wire logic sel_txctl;
   wire logic sel_irqen;
   wire logic sel_stat;
   wire logic [2:0] live_now;
   wire logic [2:0] live_chg;
   wire logic [6:0] src_evt;
   wire logic [6:0] src_en;
   wire logic [6:0] pend_set;
   wire logic stat_read;
   wire logic [7:0] stat_word;
   wire logic any_pend;

   // register bit pick, used for every field decode
   function automatic logic liu_bit(input logic [7:0] word, input int pos);
      liu_bit = word[pos[2:0]];
   endfunction : liu_bit

   // address decode
   assign sel_txctl = (reg_addr_i == `LIU_ADDR_TXCTL);
   assign sel_irqen = (reg_addr_i == `LIU_ADDR_IRQEN);
   assign sel_stat = (reg_addr_i == `LIU_ADDR_STAT);
   assign stat_read = reg_rd_i & sel_stat;

   // writable registers; bits above D4 of the tx control word do not exist
   assign txctl_d = (reg_wr_i & sel_txctl) ? (reg_wdata_i & `LIU_TXCTL_WMASK) : txctl_q;
   assign irqen_d = (reg_wr_i & sel_irqen) ? reg_wdata_i : irqen_q;

   // [RULE_01] resistor select decode
   assign rx_res_sel_o = liu_rx_res_t'({liu_bit(txctl_q, `LIU_TXCTL_RES_HI),
                                        liu_bit(txctl_q, `LIU_TXCTL_RES_LO)});

   // [RULE_05] [RULE_06] ratio select; internal termination forces 1:2
   assign tx_ratio_1to2_o = int_term_i | liu_bit(txctl_q, `LIU_TXCTL_RATIO);

   // live alarm conditions, ordered driver, fifo, line violation
   assign live_now = {driver_fail_i, fifo_near_limit_i, line_violation_i};
   // [RULE_18] change in either direction
   assign live_chg = live_now ^ live_q;

   // event sources ordered as the enable bits D6..D0
   assign src_evt = {live_chg, loop_code_evt_i, alarm_indication_evt_i,
                     loss_of_signal_evt_i, test_pattern_evt_i};

   // [RULE_08] [RULE_09] [RULE_10] driver, fifo, violation masks
   // [RULE_11] [RULE_12] [RULE_13] [RULE_14] loop, ais, los, pattern masks
   assign src_en = {liu_bit(irqen_q, `LIU_IE_DRV), liu_bit(irqen_q, `LIU_IE_FIFO),
                    liu_bit(irqen_q, `LIU_IE_LCV), liu_bit(irqen_q, `LIU_IE_LOOP),
                    liu_bit(irqen_q, `LIU_IE_AIS), liu_bit(irqen_q, `LIU_IE_LOS),
                    liu_bit(irqen_q, `LIU_IE_PAT)};
   assign pend_set = src_evt & src_en;

   // [RULE_19] sticky pending; status read clears, a same-cycle event wins
   assign pend_d = pend_set | (stat_read ? `LIU_PEND_RST : pend_q);
   assign any_pend = |pend_q;

   // [RULE_15] [RULE_16] [RULE_17] status word shows the live alarm levels
   assign stat_word = {1'b0, live_q, 4'h0};

   // read mux; unmapped addresses read as zero
   assign rdata_d = !reg_rd_i ? rdata_q :
                    sel_txctl ? txctl_q :
                    sel_irqen ? irqen_q :
                    sel_stat ? stat_word : `LIU_RDATA_RST;

   // host registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         txctl_q <= `LIU_TXCTL_RST;
         irqen_q <= `LIU_IRQEN_RST;
      end
      else
      begin
         txctl_q <= txctl_d;
         irqen_q <= irqen_d;
      end
   end

   // alarm sampling and pending flags
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         live_q <= `LIU_ST_LIVE_RST;
         pend_q <= `LIU_PEND_RST;
      end
      else
      begin
         live_q <= live_now;
         pend_q <= pend_d;
      end
   end

   // read data and pin drive from flops so the host sees stable levels
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rdata_q <= `LIU_RDATA_RST;
         int_n_q <= 1'b1;
      end
      else
      begin
         rdata_q <= rdata_d;
         // [RULE_07] global gate
         int_n_q <= ~(any_pend & liu_bit(irqen_q, `LIU_IE_GLOBAL));
      end
   end

   assign reg_rdata_o = rdata_q;
   assign int_n_o = int_n_q;

   // [RULE_02] [RULE_04] single violation per fresh rising edge of the insert bit
   liu_bpv_insert u_bpv
   (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .insert_bit_i(liu_bit(txctl_q, `LIU_TXCTL_INSERT)),
      .tx_clock_i(tx_clock_i),
      .prbs_active_i(prbs_active_i),
      .single_rail_i(single_rail_i),
      .bpv_insert_o(bpv_insert_o),
      .bpv_busy_o()
   );

endmodule : liu_alarm_ctrl

// >>> sim/liu_alarm_ctrl_chk.sv
// Purpose: port-level checks of the alarm and transmit control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: the enable mirror is rebuilt from host writes only
module liu_alarm_ctrl_chk
   import liu_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // host port
   input wire logic [4:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   // alarm sources
   input wire logic driver_fail_i,
   input wire logic fifo_near_limit_i,
   input wire logic line_violation_i,
   input wire logic loop_code_evt_i,
   input wire logic alarm_indication_evt_i,
   input wire logic loss_of_signal_evt_i,
   input wire logic test_pattern_evt_i,
   // transmit and termination
   input wire logic tx_clock_i,
   input wire logic prbs_active_i,
   input wire logic single_rail_i,
   input wire logic int_term_i,
   input wire logic bpv_insert_o,
   input wire logic tx_ratio_1to2_o,
   input wire liu_rx_res_t rx_res_sel_o,
   input wire logic int_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic [7:0] ie_q;
   logic [2:0] lvl_q;
   wire [2:0] lvl = {driver_fail_i, fifo_near_limit_i, line_violation_i};
   wire [3:0] evt = {loop_code_evt_i, alarm_indication_evt_i, loss_of_signal_evt_i,
      test_pattern_evt_i};
   wire [6:0] hit = {lvl ^ lvl_q, evt} & ie_q[6:0];
   wire rd5 = reg_rd_i && (reg_addr_i == 5'h05);
   wire rd3 = reg_rd_i && (reg_addr_i == 5'h03);
   // mirror of the enables and of the last level sample, both cleared like the design
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ie_q <= 8'h00;
         lvl_q <= 3'h0;
      end
      else
      begin
         if (reg_wr_i && reg_addr_i == 5'h04)
            ie_q <= reg_wdata_i;
         lvl_q <= lvl;
      end
   end
   property p_res; rd3 |=> rx_res_sel_o == reg_rdata_o[4:3]; endproperty
   a_res: assert property (p_res) else $error("resistor code differs from register");
   property p_ext; rd3 ##1 !int_term_i |-> tx_ratio_1to2_o == reg_rdata_o[0]; endproperty
   a_ext: assert property (p_ext) else $error("ratio does not follow its bit");
   property p_int; int_term_i |-> tx_ratio_1to2_o; endproperty
   a_int: assert property (p_int) else $error("internal ratio not fixed");
   // inputs are held stable so either sampling depth gives the same status
   property p_stat;
      rd5 && $stable(lvl) |=> reg_rdata_o == {1'b0, $past(lvl), 4'h0};
   endproperty
   a_stat: assert property (p_stat) else $error("status read wrong");
   property p_bpv;
      bpv_insert_o |-> $past(tx_clock_i) && !$past(tx_clock_i, 2)
         && $past(prbs_active_i || single_rail_i) ##1 !bpv_insert_o;
   endproperty
   a_bpv: assert property (p_bpv) else $error("violation pulse misplaced");
   property p_glob; !ie_q[7] |=> int_n_o; endproperty
   a_glob: assert property (p_glob) else $error("pin low without global enable");
   property p_src; (hit != 7'h00) && ie_q[7] |-> ##[1:3] !int_n_o; endproperty
   a_src: assert property (p_src) else $error("enabled event gave no interrupt");
   property p_hold; !int_n_o && ie_q[7] && !rd5 && !$past(rd5) |=> !int_n_o; endproperty
   a_hold: assert property (p_hold) else $error("interrupt dropped unserviced");
   c_bpv: cover property (bpv_insert_o);
   c_irq: cover property ($fell(int_n_o));
   c_clr: cover property (rd5 && !int_n_o);
endmodule : liu_alarm_ctrl_chk

bind liu_alarm_ctrl liu_alarm_ctrl_chk i_liu_alarm_ctrl_chk (.*);

// >>> sim/liu_host_model.sv
// Purpose: host side of the strobed register port
// Assumes: requests launched off the falling edge, one strobe cycle each
// Notes: write data is inverted when idle so a stale byte never looks fresh
module liu_host_model
(
   // clock and read data
   input wire logic ref_clk_i,
   input wire logic [7:0] reg_rdata_i,
   // request lines
   output logic [4:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle at time zero
   initial
   begin
      reg_addr_o = 5'h1f;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
   end
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
   endtask : wr
   // data is registered, so it is taken a half cycle after the read edge
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_o = 1'b0;
      d = reg_rdata_i;
   endtask : rd
endmodule : liu_host_model

// >>> sim/liu_alarm_interrupt_and_tx_control_test.sv
// Purpose: register-level tests of the alarm and transmit control block
// Assumes: inputs change on the falling edge, tx clock is eight system cycles
// Notes: violation counts use a window that spans several tx edges
module liu_alarm_interrupt_and_tx_control_test
   import liu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, h_wr, h_rd, tx_clk = 1'b0;
   logic prbs = 1'b0, srail = 1'b0, iterm = 1'b0, bpv, ratio, int_n;
   logic [4:0] h_addr;
   logic [7:0] h_wdata, rdata, d;
   logic [6:0] src = 7'h00;
   liu_rx_res_t res;
   int n_mismatch = 0, n_checks = 0, c;
   liu_host_model i_liu_host_model (.ref_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(h_addr),
      .reg_wr_o(h_wr), .reg_rd_o(h_rd), .reg_wdata_o(h_wdata));
   liu_alarm_ctrl i_liu_alarm_ctrl (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(h_addr),
      .reg_wr_i(h_wr), .reg_rd_i(h_rd), .reg_wdata_i(h_wdata), .reg_rdata_o(rdata),
      .driver_fail_i(src[6]), .fifo_near_limit_i(src[5]), .line_violation_i(src[4]),
      .loop_code_evt_i(src[3]), .alarm_indication_evt_i(src[2]), .loss_of_signal_evt_i(src[1]),
      .test_pattern_evt_i(src[0]), .tx_clock_i(tx_clk), .prbs_active_i(prbs),
      .single_rail_i(srail), .int_term_i(iterm), .bpv_insert_o(bpv), .tx_ratio_1to2_o(ratio),
      .rx_res_sel_o(res), .int_n_o(int_n));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   // write the control byte, then count violation pulses over five tx periods
   task automatic pulse(input logic [7:0] v, input logic [7:0] exp);
      i_liu_host_model.wr(5'h03, v);
      c = 0;
      repeat (40)
      begin
         @(negedge clk);
         c += int'(bpv === 1'b1);
      end
      chk("violations", exp, 8'(c));
   endtask : pulse
   // levels toggle, event sources give a one-cycle pulse; the pin settles within four
   task automatic fire(input int i);
      @(negedge clk);
      src[i] = ~src[i];
      if (i < 4)
      begin
         @(negedge clk);
         src[i] = 1'b0;
      end
      repeat (4) @(negedge clk);
   endtask : fire
   initial forever #5 clk = ~clk;
   initial forever
   begin
      repeat (4) @(negedge clk);
      tx_clk = ~tx_clk;
   end
   // a hang is cut short long after the tests should have ended
   initial
   begin
      #100us;
      n_mismatch++;
      results();
   end
   initial
   begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      i_liu_host_model.rd(5'h04, d);
      chk("irq enable", 8'h00, d);
      i_liu_host_model.rd(5'h03, d);
      chk("tx control", 8'h00, d);
      i_liu_host_model.rd(5'h07, d);
      chk("unmapped", 8'h00, d);
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         i_liu_host_model.wr(5'h03, 8'he1 | 8'(i << 3));
         i_liu_host_model.rd(5'h03, d);
         chk("tx control", 8'h01 | 8'(i << 3), d);
         chk("resistor", 8'(i), 8'(res));
         chk("ratio", 8'h01, 8'(ratio));
      end
      i_liu_host_model.wr(5'h03, 8'h00);
      chk("ratio", 8'h00, 8'(ratio));
      iterm = 1'b1;
      @(negedge clk);
      chk("ratio", 8'h01, 8'(ratio));
      iterm = 1'b0;
      $display("test control done");
      srail = 1'b1;
      pulse(8'h04, 8'h01);
      pulse(8'h04, 8'h00);
      pulse(8'h00, 8'h00);
      pulse(8'h04, 8'h01);
      srail = 1'b0;
      pulse(8'h00, 8'h00);
      pulse(8'h04, 8'h00);
      prbs = 1'b1;
      pulse(8'h04, 8'h01);
      $display("test violation done");
      for (int i = 6; i >= 0; i--)
      begin
         i_liu_host_model.wr(5'h04, 8'h80 | 8'(1 << i));
         fire(i);
         chk("irq pin", 8'h00, 8'(int_n));
         i_liu_host_model.wr(5'h04, 8'(1 << i));
         repeat (2) @(negedge clk);
         chk("irq pin gated", 8'h01, 8'(int_n));
         i_liu_host_model.wr(5'h04, 8'h80 | 8'(1 << i));
         repeat (2) @(negedge clk);
         chk("irq pin held", 8'h00, 8'(int_n));
         i_liu_host_model.rd(5'h05, d);
         chk("status", {1'b0, src[6:4], 4'h0}, d);
         repeat (3) @(negedge clk);
         chk("irq pin cleared", 8'h01, 8'(int_n));
         i_liu_host_model.wr(5'h04, 8'hff & ~8'(1 << i));
         fire(i);
         chk("irq pin masked", 8'h01, 8'(int_n));
      end
      fire(4);
      i_liu_host_model.rd(5'h05, d);
      chk("status", 8'h10, d);
      // the pin must be high again so the falling change below is seen on its own
      repeat (2) @(negedge clk);
      chk("irq pin cleared", 8'h01, 8'(int_n));
      fire(4);
      chk("irq pin on fall", 8'h00, 8'(int_n));
      $display("test interrupt done");
      results();
   end
endmodule : liu_alarm_interrupt_and_tx_control_test
